// [design/mrc_regs.vh]
// Register indices, field positions, reset values and timing for the bank
`ifndef MRC_REGS_VH
`define MRC_REGS_VH

// Register indices; byte address is four times the index
`define MRC_IDX_PHC_APP_CNT  8'h45
`define MRC_IDX_TOT_APP_CNT  8'h46
`define MRC_IDX_PFA          8'h47
`define MRC_IDX_PFB          8'h48
`define MRC_IDX_PFC          8'h49
`define MRC_IDX_PFT          8'h4A
`define MRC_IDX_LC_ACT       8'h4B
`define MRC_IDX_LC_REACT     8'h4C
`define MRC_IDX_SIGNS        8'h4D
`define MRC_IDX_V_AB         8'h4E
`define MRC_IDX_V_BC         8'h4F
`define MRC_IDX_V_AC         8'h50
`define MRC_IDX_VI_A         8'h51
`define MRC_IDX_VI_B         8'h52
`define MRC_IDX_VI_C         8'h53
`define MRC_IDX_IFLAG1       8'h54
`define MRC_IDX_IFLAG2       8'h55
`define MRC_IDX_IFLAG3       8'h56
`define MRC_IDX_ISUM         8'h57
`define MRC_IDX_ISUM_RMS     8'h58
`define MRC_IDX_ISUM_QRMS    8'h59
`define MRC_IDX_VARA         8'h5A
`define MRC_IDX_VARB         8'h5B
`define MRC_IDX_VARC         8'h5C
`define MRC_IDX_VART         8'h5D
`define MRC_IDX_TEMP         8'h5E
`define MRC_IDX_CUR_GAIN     8'h60
`define MRC_IDX_VOLT_GAIN    8'h61
`define MRC_IDX_LOW_PT       8'h62
`define MRC_IDX_HIGH_PT      8'h63
`define MRC_IDX_IA_DLY       8'h64
`define MRC_IDX_RMS_FLOOR    8'h70
`define MRC_IDX_EVT_STAT     8'h71
`define MRC_IDX_EVT_MASK     8'h72

// Reset values
`define MRC_RST_CUR_GAIN     24'h00_0000
`define MRC_RST_VOLT_GAIN    20'h0_0000
`define MRC_RST_LOW_PT       24'h01_0000
`define MRC_RST_HIGH_PT      24'h20_0000
`define MRC_RST_IA_DLY       24'h00_0000
`define MRC_RST_RMS_FLOOR    24'h00_0000
`define MRC_RST_EVT          3'h0

// Event bit positions
`define MRC_EVT_SEG_CHANGE   0
`define MRC_EVT_DLY_DONE     1
`define MRC_EVT_OVERRUN      2

// Gain field low bit positions
`define MRC_GAIN_IC_LSB      8
`define MRC_GAIN_IB_LSB      12
`define MRC_GAIN_IA_LSB      16
`define MRC_GAIN_IN_LSB      20
`define MRC_GAIN_VA_LSB      8
`define MRC_GAIN_VB_LSB      12
`define MRC_GAIN_VC_LSB      16

// Segment codes
`define MRC_SEG_NONE         2'h0
`define MRC_SEG_LOW          2'h1
`define MRC_SEG_MID          2'h2
`define MRC_SEG_HIGH         2'h3

// Timing: delay step and clock period in ns
`define MRC_STEP_NS          250
`define MRC_CLK_NS           40

`endif

// [design/mrc_phase_delay.v]
// Segmented phase-delay correction for the phase-A current channel
`include "mrc_regs.vh"

module mrc_phase_delay (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [23:0] delay_cal,
  input  wire [23:0] rms_floor,
  input  wire [23:0] first_segment_point,
  input  wire [23:0] second_segment_point,
  input  wire [23:0] rms_value,
  input  wire        rms_valid,
  input  wire [23:0] sample_in,
  input  wire        sample_valid,
  output reg  [23:0] sample_out,
  output reg         sample_out_valid,
  output reg  [1:0]  segment,
  output reg         seg_change,
  output reg         overrun
);

  // Step rounded up to whole cycles: 7 cycles, 280 ns at 25 MHz
  localparam integer STEP_INT =
    (`MRC_STEP_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS;
  localparam [2:0]   STEP_CYC = STEP_INT[2:0];

  reg  [1:0]  seg_next;     // Segment picked from fresh RMS
  reg  [7:0]  code;         // Correction byte of active segment
  wire [9:0]  dly_cycles;   // Requested delay in clock cycles
  reg  [9:0]  cnt_reg;      // Remaining delay
  reg         pend_reg;     // Sample waiting in the delay
  reg  [23:0] hold_reg;     // Captured sample

  // Pick segment from the RMS result being delivered
  always @* begin
    if (rms_value <= rms_floor)
      seg_next = `MRC_SEG_NONE;
    else if (rms_value < first_segment_point)
      seg_next = `MRC_SEG_LOW;
    else if (rms_value < second_segment_point)
      seg_next = `MRC_SEG_MID;
    else
      seg_next = `MRC_SEG_HIGH;
  end

  // Correction byte of the active segment, zero when disabled
  always @* begin
    case (segment)
      `MRC_SEG_LOW:  code = delay_cal[7]  ? delay_cal[7:0]   : 8'h00;
      `MRC_SEG_MID:  code = delay_cal[15] ? delay_cal[15:8]  : 8'h00;
      `MRC_SEG_HIGH: code = delay_cal[23] ? delay_cal[23:16] : 8'h00;
      default:       code = 8'h00;
    endcase
  end

  // Bit 7 is the enable, seven bits of magnitude remain
  assign dly_cycles = code[6:0] * STEP_CYC;

  // Segment moves only when a new RMS value arrives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment    <= `MRC_SEG_NONE;
      seg_change <= 1'b0;
    end else begin
      seg_change <= 1'b0;
      if (rms_valid) begin
        segment    <= seg_next;
        seg_change <= (seg_next != segment);
      end
    end
  end

  // Single-sample delay; a new sample while one waits replaces it
  // Limitation: samples must be spaced beyond the largest delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg          <= 10'h000;
      pend_reg         <= 1'b0;
      hold_reg         <= 24'h00_0000;
      sample_out       <= 24'h00_0000;
      sample_out_valid <= 1'b0;
      overrun          <= 1'b0;
    end else begin
      sample_out_valid <= 1'b0;
      overrun          <= 1'b0;
      if (sample_valid) begin
        overrun <= pend_reg;
        if (dly_cycles == 10'h000) begin
          sample_out       <= sample_in;
          sample_out_valid <= 1'b1;
          pend_reg         <= 1'b0;
        end else begin
          hold_reg <= sample_in;
          cnt_reg  <= dly_cycles - 10'h001;
          pend_reg <= 1'b1;
        end
      end else if (pend_reg) begin
        if (cnt_reg == 10'h000) begin
          sample_out       <= hold_reg;
          sample_out_valid <= 1'b1;
          pend_reg         <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 10'h001;
        end
      end
    end
  end

endmodule // mrc_phase_delay

// [design/mrc_regs_top.v]
// APB register bank for metering readout and phase calibration
`include "mrc_regs.vh"

// How it works
// - Low segment uses bits 7:0, bit 7 enables
// - Middle segment uses bits 15:8, bit 15 enables
// - Each step adds 7 cycles, 280 ns, of delay
// - High segment uses bits 23:16, bit 23 enables
// - Current gain fields at 11:8 through 23:20
// - Voltage gain register 20 bits, three fields
// - Three 16-bit voltage pair intervals readable
// - Three 16-bit voltage-current intervals readable
// - Three 24-bit interrupt flag words readable
// - Current sum, RMS, quick RMS readable
// - Die temperature readable as 10 bits
// - Line cycle active, reactive energy readable
// - Apparent pulse counts for C, total
// - Full-wave reactive power, three phases, total
// - Power factors per phase and total
// - Calibration registers writable, drive measurement path
module mrc_regs_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Event interrupt, level
  output wire        irq,

  // Measurement results from the metering engine, same clock
  input  wire [23:0] phase_c_apparent_pulse_count,
  input  wire [23:0] total_apparent_pulse_count,
  input  wire [23:0] phase_a_power_factor,
  input  wire [23:0] phase_b_power_factor,
  input  wire [23:0] phase_c_power_factor,
  input  wire [23:0] total_power_factor,
  input  wire [23:0] line_cycle_active_energy,
  input  wire [23:0] line_cycle_reactive_energy,
  input  wire [23:0] energy_pulse_sign_flags,
  input  wire [15:0] voltage_ab_interval,
  input  wire [15:0] voltage_bc_interval,
  input  wire [15:0] voltage_ac_interval,
  input  wire [15:0] phase_a_vi_interval,
  input  wire [15:0] phase_b_vi_interval,
  input  wire [15:0] phase_c_vi_interval,
  input  wire [23:0] interrupt_flags_first,
  input  wire [23:0] interrupt_flags_second,
  input  wire [23:0] interrupt_flags_third,
  input  wire [23:0] current_sum_waveform,
  input  wire [23:0] current_sum_rms,
  input  wire [23:0] current_sum_quick_rms,
  input  wire [23:0] phase_a_fullwave_reactive,
  input  wire [23:0] phase_b_fullwave_reactive,
  input  wire [23:0] phase_c_fullwave_reactive,
  input  wire [23:0] total_fullwave_reactive,
  input  wire [9:0]  die_temperature,

  // Phase-A current channel path
  input  wire [23:0] ia_rms,
  input  wire        ia_rms_valid,
  input  wire [23:0] ia_sample,
  input  wire        ia_sample_valid,
  output wire [23:0] ia_sample_delayed,
  output wire        ia_delayed_valid,
  output wire [1:0]  ia_segment,

  // Front-end amplifier gain settings
  output wire [3:0]  gain_ic,
  output wire [3:0]  gain_ib,
  output wire [3:0]  gain_ia,
  output wire [3:0]  gain_in,
  output wire [3:0]  gain_va,
  output wire [3:0]  gain_vb,
  output wire [3:0]  gain_vc
);

  // Calibration and control registers
  reg  [23:0] current_amp_gain_reg;           // Current gain fields
  reg  [19:0] voltage_amp_gain_reg;           // Voltage gain fields
  reg  [23:0] low_segment_point_reg;          // First segment point
  reg  [23:0] high_segment_point_reg;         // Second segment point
  reg  [23:0] phase_a_current_delay_cal_reg;  // Segment delay bytes
  // Own word beyond the map
  reg  [23:0] current_rms_floor_reg;          // Lower current limit
  reg  [2:0]  evt_stat_reg;                   // Sticky event flags
  reg  [2:0]  evt_mask_reg;                   // Event enables

  // Bus decode
  wire [7:0]  idx;            // Register index
  wire        aligned;        // Word aligned, within index space
  reg         hit;            // Address maps to a register
  reg         writable;       // Address maps to a writable register
  reg  [31:0] rd_mux;         // Read value of addressed register
  wire        setup_ph;       // APB setup cycle
  wire        access_ph;      // APB access cycle
  wire        wr_en;          // Write takes effect this edge
  reg         err_reg;        // Error captured at setup

  // Event sources from the delay path
  wire        ev_seg;         // Segment changed
  wire        ev_done;        // Delayed sample delivered
  wire        ev_ovr;         // Sample replaced while waiting
  // Bit 2 overrun, 1 done, 0 segment
  wire [2:0]  ev_vec;         // Events in status layout
  wire [2:0]  w1c;            // Bits software clears

  // Upper bits of read words are zero
  // Zero-extend a 24-bit value into a data word
  function [31:0] ext24;
    input [23:0] v;
    begin
      ext24 = {8'h00, v};
    end
  endfunction

  // Zero-extend a 16-bit value into a data word
  // Used by the six timing words
  function [31:0] ext16;
    input [15:0] v;
    begin
      ext16 = {16'h0000, v};
    end
  endfunction

  // Index is the word address
  assign idx       = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  // Zero wait states: read data is captured in the setup cycle
  assign pready    = 1'b1;
  assign pslverr   = access_ph && err_reg;
  // Refused writes never land
  assign wr_en     = access_ph && pwrite && !err_reg;

  // Decode shared by read and write
  // Read mux and map decode
  always @* begin
    // Default: mapped, read only, zero
    rd_mux   = 32'h0000_0000;
    hit      = 1'b1;
    writable = 1'b0;
    // Misaligned or out of range
    if (!aligned)
      hit = 1'b0;

    // Pulse counts
    else if (idx == `MRC_IDX_PHC_APP_CNT)
      rd_mux = ext24(phase_c_apparent_pulse_count);
    else if (idx == `MRC_IDX_TOT_APP_CNT)
      rd_mux = ext24(total_apparent_pulse_count);
    // Power factors
    else if (idx == `MRC_IDX_PFA)
      rd_mux = ext24(phase_a_power_factor);
    else if (idx == `MRC_IDX_PFB)
      rd_mux = ext24(phase_b_power_factor);
    else if (idx == `MRC_IDX_PFC)
      rd_mux = ext24(phase_c_power_factor);
    else if (idx == `MRC_IDX_PFT)
      rd_mux = ext24(total_power_factor);
    // Line-cycle energies
    else if (idx == `MRC_IDX_LC_ACT)
      rd_mux = ext24(line_cycle_active_energy);
    else if (idx == `MRC_IDX_LC_REACT)
      rd_mux = ext24(line_cycle_reactive_energy);
    // Pulse sign flags
    else if (idx == `MRC_IDX_SIGNS)
      rd_mux = ext24(energy_pulse_sign_flags);
    // Voltage pair timing
    else if (idx == `MRC_IDX_V_AB)
      rd_mux = ext16(voltage_ab_interval);
    else if (idx == `MRC_IDX_V_BC)
      rd_mux = ext16(voltage_bc_interval);
    else if (idx == `MRC_IDX_V_AC)
      rd_mux = ext16(voltage_ac_interval);
    // Voltage-to-current timing
    else if (idx == `MRC_IDX_VI_A)
      rd_mux = ext16(phase_a_vi_interval);
    else if (idx == `MRC_IDX_VI_B)
      rd_mux = ext16(phase_b_vi_interval);
    else if (idx == `MRC_IDX_VI_C)
      rd_mux = ext16(phase_c_vi_interval);
    // Engine interrupt words
    else if (idx == `MRC_IDX_IFLAG1)
      rd_mux = ext24(interrupt_flags_first);
    else if (idx == `MRC_IDX_IFLAG2)
      rd_mux = ext24(interrupt_flags_second);
    else if (idx == `MRC_IDX_IFLAG3)
      rd_mux = ext24(interrupt_flags_third);
    // Summed current figures
    else if (idx == `MRC_IDX_ISUM)
      rd_mux = ext24(current_sum_waveform);
    else if (idx == `MRC_IDX_ISUM_RMS)
      rd_mux = ext24(current_sum_rms);
    else if (idx == `MRC_IDX_ISUM_QRMS)
      rd_mux = ext24(current_sum_quick_rms);
    // Full-wave reactive powers
    else if (idx == `MRC_IDX_VARA)
      rd_mux = ext24(phase_a_fullwave_reactive);
    else if (idx == `MRC_IDX_VARB)
      rd_mux = ext24(phase_b_fullwave_reactive);
    else if (idx == `MRC_IDX_VARC)
      rd_mux = ext24(phase_c_fullwave_reactive);
    else if (idx == `MRC_IDX_VART)
      rd_mux = ext24(total_fullwave_reactive);
    // Die temperature
    else if (idx == `MRC_IDX_TEMP)
      rd_mux = {22'h00_0000, die_temperature};

    // Calibration words, read back
    else if (idx == `MRC_IDX_CUR_GAIN) begin
      rd_mux   = ext24(current_amp_gain_reg);
      writable = 1'b1;
    end else if (idx == `MRC_IDX_VOLT_GAIN) begin
      rd_mux   = {12'h000, voltage_amp_gain_reg};
      writable = 1'b1;
    end else if (idx == `MRC_IDX_LOW_PT) begin
      rd_mux   = ext24(low_segment_point_reg);
      writable = 1'b1;
    end else if (idx == `MRC_IDX_HIGH_PT) begin
      rd_mux   = ext24(high_segment_point_reg);
      writable = 1'b1;
    end else if (idx == `MRC_IDX_IA_DLY) begin
      rd_mux   = ext24(phase_a_current_delay_cal_reg);
      writable = 1'b1;
      // Own words: floor, status, mask
    end else if (idx == `MRC_IDX_RMS_FLOOR) begin
      rd_mux   = ext24(current_rms_floor_reg);
      writable = 1'b1;
    end else if (idx == `MRC_IDX_EVT_STAT) begin
      rd_mux   = {29'h0000_0000, evt_stat_reg};
      writable = 1'b1;
    end else if (idx == `MRC_IDX_EVT_MASK) begin
      rd_mux   = {29'h0000_0000, evt_mask_reg};
      writable = 1'b1;
    end else
      hit = 1'b0;
  end

  // Capture read data and error in the setup cycle
  // Writes to read-only words are refused with an error too
  // Early latch keeps pready high; the read
  // value is one cycle older than the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      err_reg <= !hit || (pwrite && !writable);
    end
  end

  // Calibration writes from the host steer the measurement path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_amp_gain_reg          <= `MRC_RST_CUR_GAIN;
      voltage_amp_gain_reg          <= `MRC_RST_VOLT_GAIN;
      low_segment_point_reg         <= `MRC_RST_LOW_PT;
      high_segment_point_reg        <= `MRC_RST_HIGH_PT;
      phase_a_current_delay_cal_reg <= `MRC_RST_IA_DLY;
      current_rms_floor_reg         <= `MRC_RST_RMS_FLOOR;
      // Interrupt quiet until unmasked
      evt_mask_reg                  <= `MRC_RST_EVT;
    end else if (wr_en) begin
      // Keep only each word's width
      if (idx == `MRC_IDX_CUR_GAIN)
        current_amp_gain_reg <= pwdata[23:0];
      else if (idx == `MRC_IDX_VOLT_GAIN)
        voltage_amp_gain_reg <= pwdata[19:0];
      // Point order is software's duty
      else if (idx == `MRC_IDX_LOW_PT)
        low_segment_point_reg <= pwdata[23:0];
      else if (idx == `MRC_IDX_HIGH_PT)
        high_segment_point_reg <= pwdata[23:0];
      // New bytes act on the next sample
      else if (idx == `MRC_IDX_IA_DLY)
        phase_a_current_delay_cal_reg <= pwdata[23:0];
      else if (idx == `MRC_IDX_RMS_FLOOR)
        current_rms_floor_reg <= pwdata[23:0];
      // Status clears are handled below
      else if (idx == `MRC_IDX_EVT_MASK)
        evt_mask_reg <= pwdata[2:0];
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign ev_vec = {ev_ovr, ev_done, ev_seg};
  assign w1c    = (wr_en && idx == `MRC_IDX_EVT_STAT) ? pwdata[2:0] : 3'h0;

  // Clear by writing one; set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      evt_stat_reg <= `MRC_RST_EVT;
    else
      evt_stat_reg <= (evt_stat_reg & ~w1c) | ev_vec;
  end

  // Level interrupt while any unmasked flag is set
  // No edge capture: clear the cause
  assign irq = |(evt_stat_reg & evt_mask_reg);

  // Gain fields taken straight from the registers
  // Writes reach the front end at once
  assign gain_ic = current_amp_gain_reg[`MRC_GAIN_IC_LSB +: 4];
  assign gain_ib = current_amp_gain_reg[`MRC_GAIN_IB_LSB +: 4];
  assign gain_ia = current_amp_gain_reg[`MRC_GAIN_IA_LSB +: 4];
  assign gain_in = current_amp_gain_reg[`MRC_GAIN_IN_LSB +: 4];
  assign gain_va = voltage_amp_gain_reg[`MRC_GAIN_VA_LSB +: 4];
  assign gain_vb = voltage_amp_gain_reg[`MRC_GAIN_VB_LSB +: 4];
  assign gain_vc = voltage_amp_gain_reg[`MRC_GAIN_VC_LSB +: 4];

  // Phase-A current delay path; relies on increasing points
  // Limits come straight from registers
  mrc_phase_delay u_delay (
    .pclk                 (pclk),
    .presetn              (presetn),
    .delay_cal            (phase_a_current_delay_cal_reg),
    .rms_floor            (current_rms_floor_reg),
    .first_segment_point  (low_segment_point_reg),
    .second_segment_point (high_segment_point_reg),
    .rms_value            (ia_rms),
    .rms_valid            (ia_rms_valid),
    .sample_in            (ia_sample),
    .sample_valid         (ia_sample_valid),
    .sample_out           (ia_sample_delayed),
    .sample_out_valid     (ia_delayed_valid),
    .segment              (ia_segment),
    .seg_change           (ev_seg),
    .overrun              (ev_ovr)
  );

  // Each delivered sample is a done event
  assign ev_done = ia_delayed_valid;

endmodule // mrc_regs_top

// [sim/mrc_regs_chk.sv]
// Port-level property checker for the metering register bank
module mrc_regs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] voltage_ab_interval,
  input wire logic [9:0]  die_temperature,
  input wire logic        ia_rms_valid,
  input wire logic [23:0] ia_sample,
  input wire logic        ia_sample_valid,
  input wire logic [23:0] ia_sample_delayed,
  input wire logic        ia_delayed_valid,
  input wire logic [1:0]  ia_segment,
  input wire logic [3:0]  gain_ic,
  input wire logic [3:0]  gain_ib,
  input wire logic [3:0]  gain_ia,
  input wire logic [3:0]  gain_in,
  input wire logic [3:0]  gain_va,
  input wire logic [3:0]  gain_vb,
  input wire logic [3:0]  gain_vc
);
  // One clock domain, reset disables everything
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access phase of a write or a read at one byte address
  sequence s_wr(a); psel && penable && pwrite && paddr == a; endsequence
  sequence s_rd(a); psel && penable && !pwrite && paddr == a; endsequence

  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_gcur;
    s_wr(12'h180) |=> {gain_in, gain_ia, gain_ib, gain_ic} == $past(pwdata[23:8]);
  endproperty
  a_gcur: assert property (p_gcur) else $error("current gain");
  property p_gvolt;
    s_wr(12'h184) |=> {gain_vc, gain_vb, gain_va} == $past(pwdata[19:8]);
  endproperty
  a_gvolt: assert property (p_gvolt) else $error("voltage gain");
  property p_ghold;
    !(psel && penable && pwrite) |=> $stable({gain_in, gain_ia, gain_ib,
      gain_ic, gain_vc, gain_vb, gain_va});
  endproperty
  a_ghold: assert property (p_ghold) else $error("gain moved");
  property p_seg; !ia_rms_valid |=> $stable(ia_segment); endproperty
  a_seg: assert property (p_seg) else $error("segment moved");
  // With no segment active a sample comes straight out next cycle
  property p_nodly;
    ia_sample_valid && !ia_rms_valid && ia_segment == 2'h0 |=>
      ia_delayed_valid && ia_sample_delayed == $past(ia_sample);
  endproperty
  a_nodly: assert property (p_nodly) else $error("undelayed");
  property p_ro;
    psel && penable && pwrite && paddr >= 12'h114 && paddr <= 12'h178
      |-> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("ro write ok");
  property p_hole; s_rd(12'h17C) |-> pslverr && prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole read");
  property p_temp;
    s_rd(12'h178) |-> prdata == {22'h0, $past(die_temperature)};
  endproperty
  a_temp: assert property (p_temp) else $error("temperature");
  property p_vab;
    s_rd(12'h138) |-> prdata == {16'h0, $past(voltage_ab_interval)};
  endproperty
  a_vab: assert property (p_vab) else $error("ab interval");
endmodule // mrc_regs_chk

bind mrc_regs_top mrc_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .voltage_ab_interval,
  .die_temperature, .ia_rms_valid, .ia_sample, .ia_sample_valid,
  .ia_sample_delayed, .ia_delayed_valid, .ia_segment, .gain_ic, .gain_ib,
  .gain_ia, .gain_in, .gain_va, .gain_vb, .gain_vc);

// [sim/mrc_regs_top_bench.sv]
// Self-checking bench for the metering register bank
module mrc_regs_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, ia_delayed_valid;
  logic ia_rms_valid = 0, ia_sample_valid = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [23:0] ia_rms = 24'h0, ia_sample = 24'h0, ia_sample_delayed;
  logic [1:0]  ia_segment;
  logic [3:0]  gain_ic, gain_ib, gain_ia, gain_in, gain_va, gain_vb, gain_vc;
  logic [23:0] meas [26] = '{default: 24'h0}; // Measurement inputs
  logic [32:0] rq [$];  // Expected {error, read data} per transfer
  logic [55:0] dq [$];  // Expected {cycle, sample} per delayed output
  logic [31:0] v;
  int miscompares = 0, cmp_count = 0, cyc = 0;

  // 25 MHz clock and a free cycle count for latency checks
  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  mrc_regs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq,
    .phase_c_apparent_pulse_count(meas[0]),
    .total_apparent_pulse_count(meas[1]), .phase_a_power_factor(meas[2]),
    .phase_b_power_factor(meas[3]), .phase_c_power_factor(meas[4]),
    .total_power_factor(meas[5]), .line_cycle_active_energy(meas[6]),
    .line_cycle_reactive_energy(meas[7]),
    .energy_pulse_sign_flags(meas[8]),
    .voltage_ab_interval(meas[9][15:0]),
    .voltage_bc_interval(meas[10][15:0]),
    .voltage_ac_interval(meas[11][15:0]),
    .phase_a_vi_interval(meas[12][15:0]),
    .phase_b_vi_interval(meas[13][15:0]),
    .phase_c_vi_interval(meas[14][15:0]),
    .interrupt_flags_first(meas[15]), .interrupt_flags_second(meas[16]),
    .interrupt_flags_third(meas[17]), .current_sum_waveform(meas[18]),
    .current_sum_rms(meas[19]), .current_sum_quick_rms(meas[20]),
    .phase_a_fullwave_reactive(meas[21]),
    .phase_b_fullwave_reactive(meas[22]),
    .phase_c_fullwave_reactive(meas[23]),
    .total_fullwave_reactive(meas[24]), .die_temperature(meas[25][9:0]),
    .ia_rms, .ia_rms_valid, .ia_sample, .ia_sample_valid, .ia_sample_delayed,
    .ia_delayed_valid, .ia_segment, .gain_ic, .gain_ib, .gain_ia, .gain_in,
    .gain_va, .gain_vb, .gain_vc);

  // One comparison; four-state equality so an unknown matches only an unknown
  task chk(input string n, input logic [55:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // APB transfer; expectation noted at setup, checked by the watcher
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    rq.push_back(e);
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin miscompares++; tally_and_finish; end
    psel <= 0; penable <= 0;
  endtask

  // Program the delay code, set the RMS, send one sample of latency d
  task dly(input logic [23:0] rms, cal, input logic [1:0] sg, input int d);
    logic [23:0] s; int n;
    s = $urandom;
    apb(1, 12'h190, {8'h0, cal}, 33'h0);
    @(posedge pclk); ia_rms <= rms; ia_rms_valid <= 1;
    @(posedge pclk); ia_rms_valid <= 0;
    repeat (2) @(posedge pclk);
    chk("segment", ia_segment, sg);
    ia_sample <= s; ia_sample_valid <= 1;
    dq.push_back({cyc + d + 2, s});
    @(posedge pclk); ia_sample_valid <= 0;
    n = 0;
    while (dq.size() > 0 && n < 400) begin @(posedge pclk); n++; end
    if (n >= 400) begin miscompares++; tally_and_finish; end
  endtask

  // Watchers take the oldest note whenever a result shows
  always @(negedge pclk) begin
    if (psel && penable && pready)
      chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, rq.pop_front());
    if (ia_delayed_valid === 1'b1)
      chk("delayed", {cyc, ia_sample_delayed}, dq.pop_front());
  end

  initial begin
    #4000000;
    miscompares++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(28350));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h180, 32'h0, 33'h0);
    apb(0, 12'h184, 32'h0, 33'h0);
    apb(0, 12'h188, 32'h0, 33'h0_0001_0000);
    apb(0, 12'h18C, 32'h0, 33'h0_0020_0000);
    apb(0, 12'h190, 32'h0, 33'h0);
    @(posedge pclk);
    foreach (meas[i]) meas[i] <= $urandom;
    @(negedge pclk);
    for (int i = 0; i < 26; i++) begin
      v = (i >= 9 && i <= 14) ? 32'h0000_FFFF
        : (i == 25) ? 32'h0000_03FF : 32'h00FF_FFFF;
      apb(0, 12'(12'h114 + 4 * i), 32'h0, {1'b0, v & meas[i]});
    end
    apb(0, 12'h17C, 32'h0, 33'h1_0000_0000);
    apb(0, 12'h181, 32'h0, 33'h1_0000_0000);
    apb(1, 12'h114, 32'h0, 33'h1_0000_0000);
    apb(0, 12'h114, 32'h0, {9'h0, meas[0]});
    apb(1, 12'h180, 32'hFFFF_FFFF, 33'h0);
    apb(0, 12'h180, 32'h0, 33'h0_00FF_FFFF);
    apb(1, 12'h184, 32'hFFFF_FFFF, 33'h0);
    apb(0, 12'h184, 32'h0, 33'h0_000F_FFFF);
    apb(1, 12'h180, 32'h0012_3456, 33'h0);
    @(negedge pclk);
    chk("gain_cur", {gain_in, gain_ia, gain_ib, gain_ic}, 16'h1234);
    v = $urandom;
    apb(1, 12'h184, v, 33'h0);
    @(negedge pclk);
    chk("gain_volt", {gain_vc, gain_vb, gain_va}, v[19:8]);
    dly(24'h00_0100, 24'h00_0085, 2'h1, 35);
    dly(24'h01_0000, 24'h00_8300, 2'h2, 21);
    dly(24'h20_0000, 24'h81_0000, 2'h3, 7);
    dly(24'h01_0000, 24'h85_7F85, 2'h2, 0);
    dly(24'h00_0000, 24'h85_8585, 2'h0, 0);
    @(posedge pclk);
    ia_rms <= 24'h30_0000;
    repeat (3) @(posedge pclk);
    chk("segment", ia_segment, 2'h0);
    chk("irq", irq, 1'b0);
    apb(0, 12'h1C4, 32'h0, 33'h0_0000_0003);
    apb(1, 12'h1C8, 32'h0000_0002, 33'h0);
    @(negedge pclk);
    chk("irq", irq, 1'b1);
    apb(1, 12'h1C4, 32'h0000_0007, 33'h0);
    @(negedge pclk);
    chk("irq", irq, 1'b0);
    apb(0, 12'h1C4, 32'h0, 33'h0);
    tally_and_finish;
  end
endmodule // mrc_regs_top_bench
